// [src/crf_core_regs.sv]
// Purpose: Programmer-visible register set of an 8-bit core
// Assumes: One command per cycle from the sequencer, AXI4-Lite access
// Notes: Bus writes win over a sequencer update of the same register
// Operation
// - Program storage read-only, no write path
// - 256 bytes read/write data, stack included
// - Six registers, 16-bit program counter
// - Accumulator is 8-bit general register
// - Accumulator pairs with Y as word
// - Indexed address adds index to operand
// - Index registers increment, decrement, compare, load
// - 8-bit stack pointer, auto-updated
// - Stack accesses fall in 1C0-1FF
// - Reset leaves stack pointer unloaded
// - Program counter has two byte halves
// - Reset holds program counter at FFFE
// - Status word holds the condition flags
// - Carry from arithmetic, shifts and rotates
// - Zero flag set on zero result
// - Interrupt enable gates, auto-clears on service
// - Overflow on signed range, dedicated clear
// - Half-carry from bit 3, cleared only
// - Stack pointer decrements after save
`timescale 1ns/1ps
`include "crf_map.svh"
module crf_core_regs
  import crf_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Sequencer commands
  input wire logic seq_valid,
  input wire crf_cmd_type seq_cmd,
  // External inputs
  input wire logic ext_irq_input_a,
  input wire logic event_count_input_a,
  // Register state
  output logic [7:0] acc_q,
  output logic [7:0] x_q,
  output logic [7:0] y_q,
  output logic [7:0] stack_pointer_reg_q,
  output crf_psw_type processor_status_word_q,
  output logic [7:0] prog_counter_high_q,
  output logic [7:0] prog_counter_low_q,
  output logic [15:0] acc_pair_word,
  // Addresses and data to the sequencer
  output logic [$clog2(`CRF_PROG_BYTES)-1:0] prog_fetch_addr,
  output logic [15:0] eff_addr_q,
  output logic [8:0] stk_addr_q,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid_q,
  output logic irq_take_q
);
  function automatic logic [7:0] sel_val(input crf_sel_type s, input logic [7:0] a,
                                         input logic [7:0] x, input logic [7:0] y,
                                         input logic [7:0] sp);
    logic [7:0] r;
    r = a;
    if (s == SEL_X) begin
      r = x;
    end else if (s == SEL_Y) begin
      r = y;
    end else if (s == SEL_SP) begin
      r = sp;
    end
    return r;
  endfunction

  function automatic logic [8:0] stk_addr(input logic [7:0] sp);
    return `CRF_STK_BASE | {3'b000, sp[5:0]};
  endfunction

  logic aw_rdy_q, w_rdy_q, b_vld_q, ar_rdy_q, r_vld_q;
  logic aw_got_q, w_got_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic [1:0] b_resp_q, r_resp_q;
  logic [31:0] r_data_q;
  logic aw_take, w_take, ar_take, wr_fire;
  logic aw_got_d, w_got_d, b_vld_d, r_vld_d;
  logic wr_ok, wr_acc, wr_x, wr_y, wr_sp, wr_psw, wr_pcl, wr_pch;
  logic [31:0] rd_mux;
  logic rd_ok;
  crf_op_type op;
  logic [7:0] arg8, cur, res_d, alu_res;
  logic alu_c, alu_h, alu_v, alu_sub, alu_cin;
  logic res_we, nz_upd, pair_we;
  logic [15:0] pair_d;
  logic [16:0] wsum;
  crf_psw_type psw_d;
  logic push, pop, mwr, mrd;
  logic ram_we, ram_re;
  logic [7:0] ram_waddr, ram_wdata, ram_raddr, sp_inc;
  logic [`CRF_PULSE_MIN-1:0] irq_hist_q, ecnt_hist_q;
  logic [7:0] ecnt_q;

  // AXI4-Lite handshakes
  assign aw_take = s_axi_awvalid && aw_rdy_q;
  assign w_take = s_axi_wvalid && w_rdy_q;
  assign ar_take = s_axi_arvalid && ar_rdy_q;
  assign wr_fire = aw_got_q && w_got_q && !b_vld_q;
  assign aw_got_d = aw_take || (aw_got_q && !wr_fire);
  assign w_got_d = w_take || (w_got_q && !wr_fire);
  assign b_vld_d = wr_fire || (b_vld_q && !s_axi_bready);
  assign r_vld_d = ar_take || (r_vld_q && !s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_rdy_q <= 1'b0;
      w_rdy_q <= 1'b0;
      b_vld_q <= 1'b0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      aw_rdy_q <= !aw_got_d && !b_vld_d;
      w_rdy_q <= !w_got_d && !b_vld_d;
      b_vld_q <= b_vld_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 8'h00;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      b_resp_q <= `CRF_RESP_OK;
    end else begin
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        b_resp_q <= wr_ok ? `CRF_RESP_OK : `CRF_RESP_ERR;
      end
    end
  end

  // Register write decode, only byte lane 0 carries data
  always_comb begin
    wr_acc = 1'b0;
    wr_x = 1'b0;
    wr_y = 1'b0;
    wr_sp = 1'b0;
    wr_psw = 1'b0;
    wr_pcl = 1'b0;
    wr_pch = 1'b0;
    wr_ok = 1'b1;
    if (aw_addr_q == `CRF_OFF_ACC) begin
      wr_acc = wr_fire && w_lane_q;
    end else if (aw_addr_q == `CRF_OFF_X) begin
      wr_x = wr_fire && w_lane_q;
    end else if (aw_addr_q == `CRF_OFF_Y) begin
      wr_y = wr_fire && w_lane_q;
    end else if (aw_addr_q == `CRF_OFF_SP) begin
      wr_sp = wr_fire && w_lane_q;
    end else if (aw_addr_q == `CRF_OFF_PSW) begin
      wr_psw = wr_fire && w_lane_q;
    end else if (aw_addr_q == `CRF_OFF_PCL) begin
      wr_pcl = wr_fire && w_lane_q;
    end else if (aw_addr_q == `CRF_OFF_PCH) begin
      wr_pch = wr_fire && w_lane_q;
    end else if (aw_addr_q != `CRF_OFF_PAIR && aw_addr_q != `CRF_OFF_ECNT) begin
      wr_ok = 1'b0;
    end
  end

  // Register read decode
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == `CRF_OFF_ACC) begin
      rd_mux[7:0] = acc_q;
    end else if (s_axi_araddr == `CRF_OFF_X) begin
      rd_mux[7:0] = x_q;
    end else if (s_axi_araddr == `CRF_OFF_Y) begin
      rd_mux[7:0] = y_q;
    end else if (s_axi_araddr == `CRF_OFF_SP) begin
      rd_mux[7:0] = stack_pointer_reg_q;
    end else if (s_axi_araddr == `CRF_OFF_PSW) begin
      rd_mux[7:0] = processor_status_word_q;
    end else if (s_axi_araddr == `CRF_OFF_PCL) begin
      rd_mux[7:0] = prog_counter_low_q;
    end else if (s_axi_araddr == `CRF_OFF_PCH) begin
      rd_mux[7:0] = prog_counter_high_q;
    end else if (s_axi_araddr == `CRF_OFF_PAIR) begin
      rd_mux[15:0] = acc_pair_word;
    end else if (s_axi_araddr == `CRF_OFF_ECNT) begin
      rd_mux[7:0] = ecnt_q;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_q <= 1'b0;
      r_vld_q <= 1'b0;
      r_data_q <= 32'h0000_0000;
      r_resp_q <= `CRF_RESP_OK;
    end else begin
      ar_rdy_q <= !r_vld_d;
      r_vld_q <= r_vld_d;
      if (ar_take) begin
        r_data_q <= rd_mux;
        r_resp_q <= rd_ok ? `CRF_RESP_OK : `CRF_RESP_ERR;
      end
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = w_rdy_q;
  assign s_axi_bvalid = b_vld_q;
  assign s_axi_bresp = b_resp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid = r_vld_q;
  assign s_axi_rdata = r_data_q;
  assign s_axi_rresp = r_resp_q;

  // Command decode
  assign op = seq_valid ? seq_cmd.op : OP_NOP;
  assign arg8 = seq_cmd.arg[7:0];
  assign cur = sel_val(seq_cmd.sel, acc_q, x_q, y_q, stack_pointer_reg_q);
  assign alu_sub = (op == OP_SUB) || (op == OP_CMP);
  assign alu_cin = (op == OP_CMP) ? 1'b1 : processor_status_word_q.c;
  assign wsum = {1'b0, acc_pair_word} + {1'b0, seq_cmd.arg};

  crf_alu u_alu (
    .a(cur),
    .b(arg8),
    .cin(alu_cin),
    .sub(alu_sub),
    .res(alu_res),
    .c(alu_c),
    .h(alu_h),
    .v(alu_v)
  );

  always_comb begin
    res_d = cur;
    res_we = 1'b0;
    nz_upd = 1'b0;
    pair_we = 1'b0;
    pair_d = seq_cmd.arg;
    psw_d = processor_status_word_q;
    case (op)
      OP_LD: begin
        res_d = arg8;
        res_we = 1'b1;
        nz_upd = 1'b1;
      end
      OP_ADD, OP_SUB: begin
        res_d = alu_res;
        res_we = 1'b1;
        nz_upd = 1'b1;
        psw_d.c = alu_c;
        psw_d.h = alu_h;
        psw_d.v = alu_v;
      end
      OP_CMP: begin
        res_d = alu_res;
        nz_upd = 1'b1;
        psw_d.c = alu_c;
      end
      OP_INC: begin
        res_d = cur + 8'h01;
        res_we = 1'b1;
        nz_upd = 1'b1;
      end
      OP_DEC: begin
        res_d = cur - 8'h01;
        res_we = 1'b1;
        nz_upd = 1'b1;
      end
      OP_ASL: begin
        res_d = {cur[6:0], 1'b0};
        res_we = 1'b1;
        nz_upd = 1'b1;
        psw_d.c = cur[7];
      end
      OP_ROR: begin
        res_d = {processor_status_word_q.c, cur[7:1]};
        res_we = 1'b1;
        nz_upd = 1'b1;
        psw_d.c = cur[0];
      end
      OP_WLD: begin
        pair_we = 1'b1;
        psw_d.n = pair_d[15];
        psw_d.z = (pair_d == 16'h0000);
      end
      OP_WADD: begin
        pair_we = 1'b1;
        pair_d = wsum[15:0];
        psw_d.c = wsum[16];
        psw_d.v = (acc_pair_word[15] == seq_cmd.arg[15]) && (wsum[15] != acc_pair_word[15]);
        psw_d.n = wsum[15];
        psw_d.z = (wsum[15:0] == 16'h0000);
      end
      OP_EI: psw_d.i = 1'b1;
      OP_DI: psw_d.i = 1'b0;
      OP_IACK: psw_d.i = 1'b0;
      OP_OVERFLOW_CLEAR_INSTR: begin
        psw_d.v = 1'b0;
        psw_d.h = 1'b0;
      end
      OP_BIT: begin
        psw_d.n = arg8[7];
        psw_d.v = arg8[6];
        psw_d.z = ((acc_q & arg8) == 8'h00);
      end
      OP_BRK: psw_d.b = 1'b1;
      OP_SETG: psw_d.g = 1'b1;
      OP_CLRG: psw_d.g = 1'b0;
      default: begin
      end
    endcase
    if (nz_upd) begin
      psw_d.n = res_d[7];
      psw_d.z = (res_d == 8'h00);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 8'h00;
    end else if (wr_acc) begin
      acc_q <= w_data_q;
    end else if (pair_we) begin
      acc_q <= pair_d[7:0];
    end else if (res_we && seq_cmd.sel == SEL_ACC) begin
      acc_q <= res_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_q <= 8'h00;
    end else if (wr_x) begin
      x_q <= w_data_q;
    end else if (res_we && seq_cmd.sel == SEL_X) begin
      x_q <= res_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      y_q <= 8'h00;
    end else if (wr_y) begin
      y_q <= w_data_q;
    end else if (pair_we) begin
      y_q <= pair_d[15:8];
    end else if (res_we && seq_cmd.sel == SEL_Y) begin
      y_q <= res_d;
    end
  end

  assign acc_pair_word = {y_q, acc_q};

  assign push = (op == OP_PUSH);
  assign pop = (op == OP_POP);
  assign mwr = (op == OP_MWR);
  assign mrd = (op == OP_MRD);
  assign sp_inc = stack_pointer_reg_q + 8'h01;

  // no reset term on the stack pointer
  always_ff @(posedge aclk) begin
    if (wr_sp) begin
      stack_pointer_reg_q <= w_data_q;
    end else if (push) begin
      stack_pointer_reg_q <= stack_pointer_reg_q - 8'h01;
    end else if (pop) begin
      stack_pointer_reg_q <= sp_inc;
    end else if (res_we && seq_cmd.sel == SEL_SP) begin
      stack_pointer_reg_q <= res_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      processor_status_word_q <= `CRF_PSW_RESET;
    end else if (wr_psw) begin
      processor_status_word_q <= w_data_q;
    end else begin
      processor_status_word_q <= psw_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_counter_high_q <= `CRF_PCH_RESET;
      prog_counter_low_q <= `CRF_PCL_RESET;
    end else if (wr_pcl || wr_pch) begin
      if (wr_pch) begin
        prog_counter_high_q <= w_data_q;
      end
      if (wr_pcl) begin
        prog_counter_low_q <= w_data_q;
      end
    end else if (op == OP_PCLD) begin
      {prog_counter_high_q, prog_counter_low_q} <= seq_cmd.arg;
    end else if (op == OP_PCINC) begin
      {prog_counter_high_q, prog_counter_low_q} <= {prog_counter_high_q, prog_counter_low_q} + 16'h0001;
    end
  end

  // fetch address only, no path writes program storage
  assign prog_fetch_addr = {prog_counter_high_q[3:0], prog_counter_low_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eff_addr_q <= 16'h0000;
    end else if (op == OP_IDX) begin
      eff_addr_q <= seq_cmd.arg + {8'h00, (seq_cmd.sel == SEL_Y) ? y_q : x_q};
    end
  end

  assign ram_we = push || mwr;
  assign ram_waddr = push ? 8'(stk_addr(stack_pointer_reg_q))
                          : seq_cmd.arg[7:0];
  assign ram_wdata = push ? arg8 : cur;
  assign ram_re = pop || mrd;
  assign ram_raddr = pop ? 8'(stk_addr(sp_inc)) : seq_cmd.arg[7:0];

  crf_data_ram u_ram (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .re(ram_re),
    .raddr(ram_raddr),
    .rdata_q(mem_rdata)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_rvalid_q <= 1'b0;
      stk_addr_q <= `CRF_STK_TOP;
    end else begin
      mem_rvalid_q <= ram_re;
      if (push) begin
        stk_addr_q <= stk_addr(stack_pointer_reg_q);
      end else if (pop) begin
        stk_addr_q <= stk_addr(sp_inc);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_hist_q <= '0;
      ecnt_hist_q <= '0;
      ecnt_q <= 8'h00;
      irq_take_q <= 1'b0;
    end else begin
      irq_hist_q <= {irq_hist_q[`CRF_PULSE_MIN-2:0], ext_irq_input_a};
      ecnt_hist_q <= {ecnt_hist_q[`CRF_PULSE_MIN-2:0], event_count_input_a};
      if (ecnt_hist_q == {1'b0, {(`CRF_PULSE_MIN-1){1'b1}}} && event_count_input_a) begin
        ecnt_q <= ecnt_q + 8'h01;
      end
      irq_take_q <= (&irq_hist_q) && processor_status_word_q.i;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_PC_RESET: assert property (disable iff (1'b0)
    !aresetn |=> {prog_counter_high_q, prog_counter_low_q} == 16'hFFFE)
    else $error("program counter not at reset address");
  AST_SP_PUSH: assert property (
    push && !wr_sp |=> stack_pointer_reg_q == $past(stack_pointer_reg_q) - 8'h01)
    else $error("stack pointer did not step down after save");
  AST_SP_POP: assert property (
    pop && !wr_sp |=> stack_pointer_reg_q == $past(stack_pointer_reg_q) + 8'h01 && mem_rvalid_q)
    else $error("stack pointer not stepped up on restore");
  AST_STACK_WIN: assert property (
    ram_we && push |-> ram_waddr[7:6] == 2'h3 && mem_rvalid_q == $past(ram_re))
    else $error("stack write outside the stack window");
  AST_ZERO: assert property (
    op == OP_LD && seq_cmd.sel == SEL_X && !wr_psw
    |=> processor_status_word_q.z == (x_q == 8'h00))
    else $error("zero flag does not match loaded value");
  AST_ASL_C: assert property (
    op == OP_ASL && !wr_psw |=> processor_status_word_q.c == $past(cur[7]))
    else $error("shift carry wrong");
  AST_IACK: assert property (
    op == OP_IACK && !wr_psw |=> !processor_status_word_q.i ##1 !irq_take_q)
    else $error("interrupt enable not cleared on service");
  AST_IRQ_HOLD: assert property (
    $rose(irq_take_q) |-> $past(ext_irq_input_a, 2) && $past(ext_irq_input_a, 3))
    else $error("interrupt taken on a short pulse");
  AST_OVERFLOW_CLEAR_INSTR: assert property (
    op == OP_OVERFLOW_CLEAR_INSTR && !wr_psw |=> !processor_status_word_q.v && !processor_status_word_q.h)
    else $error("overflow clear left a flag set");
  AST_PAIR: assert property (
    op == OP_WLD && !wr_acc && !wr_y |=> acc_pair_word == $past(seq_cmd.arg))
    else $error("word load into pair failed");
  AST_IDX: assert property (
    op == OP_IDX && seq_cmd.sel == SEL_Y |=> eff_addr_q == $past(seq_cmd.arg) + {8'h00, $past(y_q)})
    else $error("indexed address wrong");
  AST_BHOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  COV_PUSH_POP: cover property (push ##[1:8] pop ##1 mem_rvalid_q);
  COV_IRQ: cover property (op == OP_EI ##[1:8] irq_take_q);
  COV_BUS_WR: cover property (wr_fire && wr_ok ##1 s_axi_bvalid);
  COV_BUS_ERR: cover property (r_vld_q && r_resp_q == `CRF_RESP_ERR);
endmodule

// [src/crf_map.svh]
// Purpose: Offsets, reset values and counts of the core register set
// Assumes: Byte addresses on the register bus, 32-bit aligned words
// Notes: Definitions only
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
`define CRF_OFF_ACC 8'h00
`define CRF_OFF_X 8'h04
`define CRF_OFF_Y 8'h08
`define CRF_OFF_SP 8'h0C
`define CRF_OFF_PSW 8'h10
`define CRF_OFF_PCL 8'h14
`define CRF_OFF_PCH 8'h18
`define CRF_OFF_PAIR 8'h1C
`define CRF_OFF_ECNT 8'h20
`define CRF_PCH_RESET 8'hFF
`define CRF_PCL_RESET 8'hFE
`define CRF_PSW_RESET 8'h00
`define CRF_STK_BASE 9'h1C0
`define CRF_STK_TOP 9'h1FF
`define CRF_PROG_BYTES 4096
`define CRF_RAM_BYTES 256
`define CRF_PULSE_MIN 2
`define CRF_RESP_OK 2'h0
`define CRF_RESP_ERR 2'h2
`endif

// [src/crf_pkg.sv]
// Purpose: Types shared by the core register set
// Assumes: Nothing beyond the map header
// Notes: Status word fields run from bit 7 down to bit 0
package crf_pkg;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_LD = 5'h01, OP_ADD = 5'h02, OP_SUB = 5'h03,
    OP_CMP = 5'h04, OP_INC = 5'h05, OP_DEC = 5'h06, OP_ASL = 5'h07,
    OP_ROR = 5'h08, OP_WLD = 5'h09, OP_WADD = 5'h0A, OP_IDX = 5'h0B,
    OP_PUSH = 5'h0C, OP_POP = 5'h0D, OP_MWR = 5'h0E, OP_MRD = 5'h0F,
    OP_PCLD = 5'h10, OP_PCINC = 5'h11, OP_EI = 5'h12, OP_DI = 5'h13,
    OP_OVERFLOW_CLEAR_INSTR = 5'h14, OP_BIT = 5'h15, OP_BRK = 5'h16, OP_IACK = 5'h17,
    OP_SETG = 5'h18, OP_CLRG = 5'h19
  } crf_op_type;
  typedef enum logic [1:0] {
    SEL_ACC = 2'h0, SEL_X = 2'h1, SEL_Y = 2'h2, SEL_SP = 2'h3
  } crf_sel_type;
  typedef struct packed {
    crf_op_type op;
    crf_sel_type sel;
    logic [15:0] arg;
  } crf_cmd_type;
  typedef struct packed {
    logic n;
    logic v;
    logic g;
    logic b;
    logic h;
    logic i;
    logic z;
    logic c;
  } crf_psw_type;
endpackage

// [src/crf_alu.sv]
// Purpose: 8-bit adder with carry, half-carry and overflow
// Assumes: Subtract is add of the inverted operand, carry set means no borrow
// Notes: Purely combinational
`timescale 1ns/1ps
module crf_alu
  import crf_pkg::*;
(
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic sub,
  // Result and flags
  output logic [7:0] res,
  output logic c,
  output logic h,
  output logic v
);
  logic [7:0] bb;
  logic [8:0] sum;
  logic [4:0] low;
  assign bb = sub ? ~b : b;
  assign sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
  assign low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
  assign res = sum[7:0];
  assign c = sum[8];
  assign h = low[4];
  assign v = (a[7] == bb[7]) && (sum[7] != a[7]);
endmodule

// [src/crf_data_ram.sv]
// Purpose: Read/write data storage, stack page included
// Assumes: One write and one read port
// Notes: Read data comes from a register one cycle after the request
`timescale 1ns/1ps
`include "crf_map.svh"
module crf_data_ram
  import crf_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic re,
  input wire logic [7:0] raddr,
  output logic [7:0] rdata_q
);
  logic [7:0] mem [0:`CRF_RAM_BYTES-1];
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 8'h00;
    end else if (re) begin
      rdata_q <= mem[raddr];
    end
  end
endmodule

// [verification/crf_seq_model.sv]
// Purpose: Sequencer stand-in that issues commands
// Assumes: Requests change just after a rising edge
// Notes: Idle command lines show the inverse pattern
`timescale 1ns/1ps
module crf_seq_model
  import crf_pkg::*;
(
  // Clock and requests
  input wire logic aclk,
  input wire logic go,
  input wire crf_cmd_type cmd,
  input wire logic irq_go,
  // Toward the register set
  output logic seq_valid,
  output crf_cmd_type seq_cmd,
  output logic pulse
);
  logic hold_q = 1'b0;
  assign seq_valid = go;
  assign seq_cmd = go ? cmd : ~cmd;
  always_ff @(posedge aclk) begin
    hold_q <= irq_go;
  end
  assign pulse = irq_go | hold_q;
endmodule

// [verification/test_crf_core_regs.sv]
// Purpose: Self-checking bench for the core register set
// Assumes: Partner model drives sequencer commands
// Notes: Random operands from a fixed seed
`timescale 1ns/1ps
`include "crf_map.svh"
module test_crf_core_regs
  import crf_pkg::*;
;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, go = 0, irq_go = 0, c;
  logic [7:0] awa = 0, ara = 0, a, b, x;
  logic [31:0] wd = 0, rd;
  crf_cmd_type cmd = '0, sc;
  logic awr, wr, bv, arr, rv, sv, pul, mrv, itk;
  logic [1:0] bresp, rresp;
  logic [7:0] acc, xr, yr, spr, prog_counter_high, prog_counter_low, mrd;
  crf_psw_type st;
  logic [15:0] pw, eff;
  logic [11:0] pfa;
  logic [8:0] stk;
  logic [10:0] e;
  int errors = 0, checks = 0, cyc = 0;
  crf_seq_model seq_u (.aclk(aclk), .go(go), .cmd(cmd), .irq_go(irq_go), .seq_valid(sv), .seq_cmd(sc), .pulse(pul));
  crf_core_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .seq_valid(sv), .seq_cmd(sc), .ext_irq_input_a(pul), .event_count_input_a(pul), .acc_q(acc),
    .x_q(xr), .y_q(yr), .stack_pointer_reg_q(spr), .processor_status_word_q(st),
    .prog_counter_high_q(prog_counter_high), .prog_counter_low_q(prog_counter_low), .acc_pair_word(pw), .prog_fetch_addr(pfa),
    .eff_addr_q(eff), .stk_addr_q(stk), .mem_rdata(mrd), .mem_rvalid_q(mrv), .irq_take_q(itk));
  initial begin
    forever #4 aclk = ~aclk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    awv <= 1;
    wv <= 1;
    awa <= ad;
    wd <= d;
    br <= 1;
    do begin
      @(posedge aclk);
      if (awr === 1'b1) awv <= 0;
      if (wr === 1'b1) wv <= 0;
    end while (bv !== 1'b1);
    chk("bresp", bresp, er);
    br <= 0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] ad, input logic [31:0] x, input logic [1:0] er);
    arv <= 1;
    ara <= ad;
    rr <= 1;
    do begin
      @(posedge aclk);
      if (arr === 1'b1) arv <= 0;
    end while (rv !== 1'b1);
    chk("rdata", rd, x);
    chk("rresp", rresp, er);
    rr <= 0;
    @(posedge aclk);
  endtask
  task automatic sq(input crf_op_type o, input crf_sel_type s, input logic [15:0] g);
    go <= 1;
    cmd <= '{o, s, g};
    @(posedge aclk);
    go <= 0;
    @(posedge aclk);
  endtask
  function automatic logic [10:0] fadd(input logic [7:0] p, input logic [7:0] q, input logic ci);
    logic [8:0] s;
    s = p + q + ci;
    fadd = {s[7:0], s[8], (p[3:0] + q[3:0] + ci) > 15, (p[7] == q[7]) && (s[7] != p[7])};
  endfunction
  initial begin
    void'($urandom(88679));
    repeat (6) @(posedge aclk);
    chk("pc", {prog_counter_high, prog_counter_low}, 16'hFFFE);
    chk("fetch", pfa, 12'hFFE);
    chk("flags", st, 8'h00);
    aresetn <= 1;
    repeat (3) @(posedge aclk);
    a = 8'($urandom);
    axw(`CRF_OFF_ACC, {24'h0, a}, `CRF_RESP_OK);
    axr(`CRF_OFF_ACC, {24'h0, a}, `CRF_RESP_OK);
    axw(8'h40, 32'h5, `CRF_RESP_ERR);
    axr(8'h40, 32'h0, `CRF_RESP_ERR);
    axw(`CRF_OFF_PSW, 32'h81, `CRF_RESP_OK);
    chk("flags", st, 8'h81);
    $display("test regs done");
    c = 1'b1;
    for (int i = 0; i < 24; i++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      if (i == 0) {a, b} = 16'h7F01;
      if (i == 1) {a, b} = 16'hFF01;
      sq(OP_LD, SEL_ACC, {8'h0, a});
      sq(OP_OVERFLOW_CLEAR_INSTR, SEL_ACC, 16'h0);
      sq(OP_ADD, SEL_ACC, {8'h0, b});
      e = fadd(a, b, c);
      chk("sum", acc, e[10:3]);
      chk("carry", st.c, e[2]);
      chk("zero", st.z, e[10:3] == 8'h0);
      chk("half", st.h, e[1]);
      chk("over", st.v, e[0]);
      chk("neg", st.n, e[10]);
      c = e[2];
    end
    sq(OP_LD, SEL_ACC, 16'h7F);
    sq(OP_ADD, SEL_ACC, 16'h1);
    sq(OP_LD, SEL_ACC, 16'h0);
    chk("zero", st.z, 1'b1);
    chk("over", st.v, 1'b1);
    sq(OP_OVERFLOW_CLEAR_INSTR, SEL_ACC, 16'h0);
    chk("vh", {st.v, st.h}, 2'h0);
    sq(OP_SETG, SEL_ACC, 16'h0);
    sq(OP_BRK, SEL_ACC, 16'h0);
    chk("gb", {st.g, st.b}, 2'h3);
    sq(OP_CLRG, SEL_ACC, 16'h0);
    chk("g", st.g, 1'b0);
    sq(OP_LD, SEL_Y, 16'h81);
    sq(OP_ASL, SEL_Y, 16'h0);
    chk("asl", {yr, st.c}, 9'h005);
    sq(OP_ROR, SEL_Y, 16'h0);
    chk("ror", {yr, st.c}, 9'h102);
    sq(OP_LD, SEL_X, {8'h0, a});
    sq(OP_SUB, SEL_X, {8'h0, b});
    e = fadd(a, ~b, 1'b0);
    chk("sub", {xr, st.c, st.h, st.v}, e);
    sq(OP_CMP, SEL_X, {8'h0, b});
    chk("cmp", {st.c, st.z}, {e[10:3] >= b, e[10:3] == b});
    sq(OP_DEC, SEL_X, 16'h0);
    chk("dec", xr, 8'(e[10:3] - 8'h1));
    sq(OP_BIT, SEL_ACC, {8'h0, b});
    chk("bit", {st.n, st.v, st.z}, {b[7], b[6], 1'b1});
    $display("test alu done");
    sq(OP_WLD, SEL_ACC, 16'hA55A);
    chk("pair", pw, 16'hA55A);
    chk("y", yr, 8'hA5);
    axr(`CRF_OFF_PAIR, 32'hA55A, `CRF_RESP_OK);
    sq(OP_WADD, SEL_ACC, 16'h8001);
    chk("wadd", {st.c, pw}, 17'h1255B);
    sq(OP_IDX, SEL_Y, 16'h1234);
    chk("effy", eff, 16'h1259);
    x = 8'($urandom);
    sq(OP_LD, SEL_X, {8'h0, x});
    sq(OP_INC, SEL_X, 16'h0);
    x = 8'(x + 8'h1);
    chk("x", xr, x);
    sq(OP_IDX, SEL_X, 16'h1234);
    chk("eff", eff, 16'h1234 + x);
    sq(OP_MWR, SEL_X, 16'h10);
    sq(OP_MRD, SEL_ACC, 16'h10);
    chk("mem", mrd, x);
    $display("test index done");
    axw(`CRF_OFF_SP, 32'hFF, `CRF_RESP_OK);
    a = 8'($urandom);
    b = 8'($urandom);
    sq(OP_PUSH, SEL_ACC, {8'h0, a});
    chk("stk", stk, 9'h1FF);
    sq(OP_PUSH, SEL_ACC, {8'h0, b});
    chk("ptr", spr, 8'hFD);
    sq(OP_POP, SEL_ACC, 16'h0);
    chk("pop", mrd, b);
    sq(OP_POP, SEL_ACC, 16'h0);
    chk("pop", mrd, a);
    chk("ptr", spr, 8'hFF);
    $display("test stack done");
    sq(OP_PCLD, SEL_ACC, 16'h12FF);
    sq(OP_PCINC, SEL_ACC, 16'h0);
    chk("pc", {prog_counter_high, prog_counter_low}, 16'h1300);
    chk("fetch", pfa, 12'h300);
    sq(OP_EI, SEL_ACC, 16'h0);
    irq_go <= 1;
    @(posedge aclk);
    irq_go <= 0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("take", itk, 1'b1);
    @(posedge aclk);
    sq(OP_IACK, SEL_ACC, 16'h0);
    chk("ie", st.i, 1'b0);
    sq(OP_EI, SEL_ACC, 16'h0);
    sq(OP_DI, SEL_ACC, 16'h0);
    chk("ie", st.i, 1'b0);
    axr(`CRF_OFF_ECNT, 32'h1, `CRF_RESP_OK);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    chk("ptr", spr, 8'hFF);
    chk("pc", {prog_counter_high, prog_counter_low}, 16'hFFFE);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    $display("test control done");
    test_done();
  end
endmodule
